// ===== rtl/emc_csr.sv
// control and status register logic of an ecc mos memory module
`timescale 1ns/10ps
module emc_csr
    import emc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic bus_init,
    // register access
    input wire logic csr_sel,
    input wire logic csr_rd,
    input wire logic csr_wr,
    input wire logic [1:0] csr_be,
    input wire logic [emc_pkg::REG_W-1:0] csr_wdata,
    output logic [emc_pkg::REG_W-1:0] csr_rdata,
    // memory cycle side
    input wire logic mem_valid,
    input wire logic word_read_cycle,
    input wire logic read_pause_cycle,
    input wire logic word_write_cycle,
    input wire logic byte_write_cycle,
    input wire logic [emc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic ecc_single,
    input wire logic ecc_double,
    input wire logic [emc_pkg::CHK_W-1:0] ecc_syndrome,
    input wire logic [emc_pkg::CHK_W-1:0] chk_fetched,
    output logic [emc_pkg::CHK_W-1:0] chk_store,
    output logic chk_use_csr,
    output logic correct_en,
    output logic bus_parity_error,
    output logic error_led
);
    import emc_pkg::*;

    // software control bits, hardware flags and the logged fields;
    // one 6-bit field serves check bits in diag mode and the syndrome
    // otherwise, so a read in diag mode shows whichever came last
    logic ind_en_q;
    logic dis_corr_q;
    logic diag_q;
    logic inh_ptr_q;
    logic single_error_flag_q;
    logic inh_en_q;
    logic retr_q;
    logic double_error_flag_q;
    logic [CHK_W-1:0] chk_q;
    logic [ALO_W-1:0] alo_q;
    logic [AHI_W-1:0] ahi_q;
    logic [REG_W-1:0] rdata_q;
    logic perr_q;

    // bus strobes and effective mode decodes
    logic wr_lo;
    logic wr_hi;
    logic rd_cyc;
    logic wr_cyc;
    logic protected_hit;
    logic dis_eff;
    logic diag_eff;
    logic set_single;
    logic set_uncorr;
    logic do_log;
    logic load_chk;
    logic [REGION_W-1:0] region;
    logic [REG_W-1:0] rd_mux;
    logic fld_wr_lo;
    logic fld_wr_hi;

    // byte lanes of a register write; bits 0..7 low, 8..15 high
    assign wr_lo = csr_sel & csr_wr & csr_be[0];
    assign wr_hi = csr_sel & csr_wr & csr_be[1];

    // field 10..5 writable only while diag mode is already on: the write
    // that turns diag on must not wipe a syndrome waiting to be read
    assign fld_wr_lo = wr_lo & diag_q;
    assign fld_wr_hi = wr_hi & diag_q;

    // memory cycle classes; only reads report errors
    assign rd_cyc = mem_valid & (word_read_cycle | read_pause_cycle);
    assign wr_cyc = mem_valid & (word_write_cycle | byte_write_cycle);

    // protected region decode against the pointer
    // a 16k-word region spans 32k bytes, so bits 21..15 select it
    assign region = mem_addr[REGION_LSB +: REGION_W];
    always_comb begin
        protected_hit = 1'b0;
        if (inh_en_q) begin
            if (inh_ptr_q) begin
                protected_hit = (region == REGION_SECOND);
            end else begin
                protected_hit = (region == REGION_FIRST);
            end
        end // pointer ignored when inhibit is off
    end

    // retrieval bit keeps the memory out of diagnostic check mode
    assign dis_eff = dis_corr_q & ~protected_hit;
    assign diag_eff = diag_q & ~retr_q & ~protected_hit;

    // correction applied by the datapath unless disabled here
    // the protected region always keeps full correction
    assign correct_en = ~dis_eff;

    // check bit source for memory writes
    // generated bits are used for every write outside diag mode
    assign chk_store = chk_q;
    assign chk_use_csr = diag_eff & wr_cyc;

    // error event decode for one read cycle
    always_comb begin
        set_single = 1'b0;
        set_uncorr = 1'b0;
        do_log = 1'b0;
        load_chk = 1'b0;
        if (rd_cyc) begin
            set_single = ecc_single;
            if (diag_eff) begin
                load_chk = 1'b1;
                set_uncorr = ecc_double;
                // single errors not logged here
                do_log = 1'b0;
            end else if (dis_eff) begin
                set_uncorr = ecc_single | ecc_double;
                do_log = ecc_single | ecc_double;
            end else begin
                set_uncorr = ecc_double;
                // a pending uncorrectable log is not overwritten by a single error
                do_log = ecc_double
                    | (ecc_single & ~double_error_flag_q);
            end
        end
    end

    // low-byte control bits; init clears them
    // bus_init acts like power-up for every field
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ind_en_q <= 1'b0;
            dis_corr_q <= 1'b0;
            diag_q <= 1'b0;
            inh_ptr_q <= 1'b0;
        end else if (bus_init) begin
            ind_en_q <= 1'b0;
            dis_corr_q <= 1'b0;
            diag_q <= 1'b0;
            inh_ptr_q <= 1'b0;
        end else if (wr_lo) begin
            ind_en_q <= csr_wdata[BIT_IND_EN];
            dis_corr_q <= csr_wdata[BIT_DIS_CORR];
            diag_q <= csr_wdata[BIT_DIAG];
            inh_ptr_q <= csr_wdata[BIT_INH_PTR];
        end
    end

    // single error flag; a hardware set beats a software clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            single_error_flag_q <= 1'b0;
        end else if (bus_init) begin
            single_error_flag_q <= 1'b0;
        end else if (set_single) begin
            single_error_flag_q <= 1'b1;
        end else if (wr_lo) begin
            single_error_flag_q <= csr_wdata[BIT_SINGLE];
        end
    end

    // high-byte mode bits
    // retrieval set also keeps the memory out of diag check mode
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            inh_en_q <= 1'b0;
            retr_q <= 1'b0;
        end else if (bus_init) begin
            inh_en_q <= 1'b0;
            retr_q <= 1'b0;
        end else if (wr_hi) begin
            inh_en_q <= csr_wdata[BIT_INH_EN];
            retr_q <= csr_wdata[BIT_RETR];
        end
    end

    // uncorrectable flag, also the red indicator
    // software may clear it; a same-cycle error still wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            double_error_flag_q <= 1'b0;
        end else if (bus_init) begin
            double_error_flag_q <= 1'b0;
        end else if (set_uncorr) begin
            double_error_flag_q <= 1'b1;
        end else if (wr_hi) begin
            double_error_flag_q <= csr_wdata[BIT_UNCORR];
        end
    end

    // check bit / syndrome field; hardware load beats a write
    // a diag-mode register write overwrites retrieved check bits,
    // never the address
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            chk_q <= CHK_RESET;
        end else if (bus_init) begin
            chk_q <= CHK_RESET;
        end else if (load_chk) begin
            chk_q <= chk_fetched;
        end else if (do_log) begin
            chk_q <= ecc_syndrome;
        end else begin
            // field straddles both byte lanes
            if (fld_wr_lo) begin
                chk_q[2:0] <= csr_wdata[FLD_LO +: 3];
            end
            if (fld_wr_hi) begin
                chk_q[5:3] <= csr_wdata[FLD_LO + 3 +: 3];
            end
        end
    end

    // error address log, low part and backup high part
    // only bits 21..11 are kept: the log points at a 1k block
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            alo_q <= ALO_RESET;
            ahi_q <= AHI_RESET;
        end else if (bus_init) begin
            alo_q <= ALO_RESET;
            ahi_q <= AHI_RESET;
        end else if (do_log) begin
            alo_q <= mem_addr[ALO_LSB +: ALO_W];
            ahi_q <= mem_addr[AHI_LSB +: AHI_W];
        end
    end

    // read view; field 11..5 depends on diag and retrieval bits
    always_comb begin
        rd_mux = RDATA_RESET;
        rd_mux[BIT_IND_EN] = ind_en_q;
        rd_mux[BIT_DIS_CORR] = dis_corr_q;
        rd_mux[BIT_DIAG] = diag_q;
        rd_mux[BIT_INH_PTR] = inh_ptr_q;
        rd_mux[BIT_SINGLE] = single_error_flag_q;
        rd_mux[BIT_INH_EN] = inh_en_q;
        rd_mux[BIT_RETR] = retr_q;
        rd_mux[BIT_UNCORR] = double_error_flag_q;
        if (diag_q) begin
            rd_mux[FLD_LO +: CHK_W] = chk_q;
            // marker identifies this memory type to diagnostics
            rd_mux[BIT_MARK] = inh_en_q & retr_q;
        end else if (retr_q) begin
            rd_mux[FLD_LO +: AHI_W] = ahi_q;
        end else begin
            rd_mux[FLD_LO +: ALO_W] = alo_q;
        end
    end

    // read data held in a register until the next read
    // bus_init leaves it alone; the next read refreshes it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_q <= RDATA_RESET;
        end else if (csr_sel & csr_rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign csr_rdata = rdata_q;

    // parity error line, timed with the read data
    // registered so it stands in the cycle the read data is returned
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            perr_q <= 1'b0;
        end else begin
            perr_q <= rd_cyc & ind_en_q
                & (ecc_double | (dis_eff & ecc_single));
        end
    end
    assign bus_parity_error = perr_q;

    // indicator follows bit 15; a software clear turns it off
    assign error_led = double_error_flag_q;

endmodule

// ===== rtl/emc_pkg.sv
// constants for the ecc memory control and status register logic
package emc_pkg;
    // register field positions
    localparam int unsigned BIT_IND_EN = 0;
    localparam int unsigned BIT_DIS_CORR = 1;
    localparam int unsigned BIT_DIAG = 2;
    localparam int unsigned BIT_INH_PTR = 3;
    localparam int unsigned BIT_SINGLE = 4;
    localparam int unsigned FLD_LO = 5;
    localparam int unsigned BIT_MARK = 11;
    localparam int unsigned BIT_INH_EN = 13;
    localparam int unsigned BIT_RETR = 14;
    localparam int unsigned BIT_UNCORR = 15;
    // widths
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADDR_W = 22;
    localparam int unsigned CHK_W = 6;
    localparam int unsigned ALO_W = 7;
    localparam int unsigned AHI_W = 4;
    // error address slices (byte address bits)
    localparam int unsigned ALO_LSB = 11;
    localparam int unsigned AHI_LSB = 18;
    // a 16k-word region spans byte address bits 14..0
    localparam int unsigned REGION_LSB = 15;
    localparam int unsigned REGION_W = 7;
    localparam logic [6:0] REGION_FIRST = 7'h00;
    localparam logic [6:0] REGION_SECOND = 7'h01;
    // values after reset
    localparam logic [5:0] CHK_RESET = 6'h00;
    localparam logic [6:0] ALO_RESET = 7'h00;
    localparam logic [3:0] AHI_RESET = 4'h0;
    localparam logic [15:0] RDATA_RESET = 16'h0000;
endpackage

// ===== sim/emc_chk.sv
// port-level assertions for the ecc register block
`timescale 1ns/10ps
module emc_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic bus_init,
    input wire logic csr_sel,
    input wire logic csr_rd,
    input wire logic csr_wr,
    input wire logic [1:0] csr_be,
    input wire logic [15:0] csr_wdata,
    input wire logic [15:0] csr_rdata,
    input wire logic mem_valid,
    input wire logic word_read_cycle,
    input wire logic read_pause_cycle,
    input wire logic word_write_cycle,
    input wire logic byte_write_cycle,
    input wire logic [21:0] mem_addr,
    input wire logic ecc_double,
    input wire logic chk_use_csr,
    input wire logic correct_en,
    input wire logic bus_parity_error,
    input wire logic error_led
);
    logic [3:0] lo_q;
    logic [1:0] hi_q;
    logic rd;
    logic prot;
    // shadow of software-only bits; hardware never sets them
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) {hi_q, lo_q} <= 6'h00;
        else if (bus_init) {hi_q, lo_q} <= 6'h00;
        else if (csr_sel && csr_wr) begin
            if (csr_be[0]) lo_q <= csr_wdata[3:0];
            if (csr_be[1]) hi_q <= csr_wdata[14:13];
        end
    end
    assign rd = mem_valid && (word_read_cycle || read_pause_cycle);
    assign prot = hi_q[0] && mem_addr[21:15] == {6'h00, lo_q[3]};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_parity_cause: assert property (bus_parity_error |->
        $past(rd && lo_q[0])) else $error("parity without cause");
    a_double_parity: assert property (rd && ecc_double && lo_q[0]
        |=> bus_parity_error) else $error("double without parity");
    a_led_double: assert property (rd && ecc_double && !bus_init
        |=> error_led) else $error("double without indicator");
    a_correct_mode: assert property (
        correct_en == !(lo_q[1] && !prot)) else $error("correct_en wrong");
    a_chk_select: assert property (mem_valid &&
        (word_write_cycle || byte_write_cycle) |->
        chk_use_csr == (lo_q[2] && !hi_q[1] && !prot))
        else $error("check bit source wrong");
    a_zero_bit: assert property (csr_rdata[12] == 1'b0)
        else $error("unused bit set");
    a_rdata_hold: assert property (!$past(csr_sel && csr_rd)
        |-> $stable(csr_rdata)) else $error("read data moved");
    a_ctl_readback: assert property (csr_sel && csr_rd && !csr_wr
        |=> csr_rdata[3:0] == $past(lo_q) && csr_rdata[14:13] == $past(hi_q))
        else $error("control bits read wrong");
endmodule
bind emc_csr emc_chk u_chk (
    .clk_sys(clk_sys), .reset(reset), .bus_init(bus_init),
    .csr_sel(csr_sel), .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_be(csr_be),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .mem_valid(mem_valid),
    .word_read_cycle(word_read_cycle), .read_pause_cycle(read_pause_cycle),
    .word_write_cycle(word_write_cycle), .byte_write_cycle(byte_write_cycle),
    .mem_addr(mem_addr), .ecc_double(ecc_double), .chk_use_csr(chk_use_csr),
    .correct_en(correct_en), .bus_parity_error(bus_parity_error),
    .error_led(error_led)
);

// ===== sim/emc_mem_model.sv
// storage array stand-in: keeps check bits, reports injected errors
`timescale 1ns/10ps
module emc_mem_model (
    input wire logic clk_sys,
    input wire logic mem_valid,
    input wire logic rd,
    input wire logic wr,
    input wire logic use_csr,
    input wire logic [emc_pkg::CHK_W-1:0] chk_in,
    input wire logic [1:0] inj,
    output logic ecc_single,
    output logic ecc_double,
    output logic [emc_pkg::CHK_W-1:0] ecc_syndrome,
    output logic [emc_pkg::CHK_W-1:0] chk_fetched
);
    import emc_pkg::*;
    logic [CHK_W-1:0] stored_q = 6'h00;
    logic [CHK_W-1:0] junk_q = 6'h00;
    logic live;
    // one check word only: tests revisit a single location
    always_ff @(posedge clk_sys) begin
        if (mem_valid && wr && use_csr) stored_q <= chk_in;
        junk_q <= ~junk_q;
    end
    // outside a read the lines wander so stale values never match
    assign live = mem_valid && rd;
    assign ecc_single = live ? inj[0] : junk_q[0];
    assign ecc_double = live ? inj[1] : junk_q[1];
    assign ecc_syndrome = live ? 6'h15 : junk_q;
    assign chk_fetched = live ? stored_q : junk_q;
endmodule

// ===== sim/emc_csr_tb.sv
// self-checking bench for the ecc register block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module emc_csr_tb;
    import emc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, bus_init = 1'b0;
    logic csr_sel = 1'b0, csr_rd = 1'b0, csr_wr = 1'b0, mem_valid = 1'b0;
    logic rdc = 1'b0, rpc = 1'b0, wrc = 1'b0, bwc = 1'b0;
    logic [1:0] csr_be = 2'h0, inj = 2'h0;
    logic [15:0] csr_wdata = 16'h0000, csr_rdata;
    logic [21:0] mem_addr = 22'h000000;
    logic es, ed, use_csr, correct_en, bpe, led;
    logic [5:0] syn, fetched, chk_store;
    int n_fail = 0, samples_checked = 0;
    emc_csr uut (.clk_sys(clk_sys), .reset(reset), .bus_init(bus_init),
        .csr_sel(csr_sel), .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_be(csr_be),
        .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .mem_valid(mem_valid),
        .word_read_cycle(rdc), .read_pause_cycle(rpc), .word_write_cycle(wrc),
        .byte_write_cycle(bwc), .mem_addr(mem_addr), .ecc_single(es),
        .ecc_double(ed), .ecc_syndrome(syn), .chk_fetched(fetched),
        .chk_store(chk_store), .chk_use_csr(use_csr),
        .correct_en(correct_en), .bus_parity_error(bpe), .error_led(led));
    emc_mem_model mdl (.clk_sys(clk_sys), .mem_valid(mem_valid),
        .rd(rdc || rpc), .wr(wrc || bwc), .use_csr(use_csr),
        .chk_in(chk_store), .inj(inj), .ecc_single(es), .ecc_double(ed),
        .ecc_syndrome(syn), .chk_fetched(fetched));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic wr(input logic [15:0] d, input logic [1:0] be);
        @(posedge clk_sys);
        {csr_sel, csr_wr, csr_wdata, csr_be} <= {2'h3, d, be};
        @(posedge clk_sys);
        {csr_sel, csr_wr} <= 2'h0;
    endtask
    task automatic rd(input logic [15:0] e);
        @(posedge clk_sys);
        {csr_sel, csr_rd} <= 2'h3;
        @(posedge clk_sys);
        {csr_sel, csr_rd} <= 2'h0;
        #1 `CHK("csr_rdata", e, csr_rdata)
    endtask
    // k picks read, read-pause, word write, byte write
    task automatic mem(input int k, input logic [21:0] a,
                       input logic [1:0] e, input logic p, input logic c);
        @(posedge clk_sys);
        {mem_valid, mem_addr, inj} <= {1'b1, a, e};
        {rdc, rpc, wrc, bwc} <= 4'b1000 >> k;
        #1 `CHK("correct_en", c, correct_en)
        @(posedge clk_sys);
        mem_valid <= 1'b0;
        #1 `CHK("bus_parity_error", p, bpe)
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(16'h0000);
        wr(16'h600f, 2'h3);
        rd(16'h680f);
        @(posedge clk_sys) bus_init <= 1'b1;
        @(posedge clk_sys) bus_init <= 1'b0;
        rd(16'h0000);
        wr(16'h0001, 2'h3);
        mem(0, 22'h2a5800, 2'h2, 1'b1, 1'b1);
        `CHK("error_led", 1'b1, led)
        mem(1, 22'h001800, 2'h1, 1'b0, 1'b1);
        rd(16'h8971);
        wr(16'h4000, 2'h2);
        rd(16'h4151);
        `CHK("error_led", 1'b0, led)
        wr(16'h00a5, 2'h1);
        rd(16'h42a5);
        wr(16'h0003, 2'h3);
        mem(0, 22'h001800, 2'h1, 1'b1, 1'b0);
        mem(1, 22'h003000, 2'h1, 1'b1, 1'b0);
        rd(16'h80d3);
        wr(16'h2003, 2'h3);
        mem(2, 22'h000000, 2'h0, 1'b0, 1'b1);
        mem(3, 22'h008000, 2'h0, 1'b0, 1'b0);
        wr(16'h200b, 2'h3);
        mem(2, 22'h008000, 2'h0, 1'b0, 1'b1);
        wr(16'h0004, 2'h3);
        wr(16'h05a4, 2'h3);
        mem(3, 22'h001800, 2'h0, 1'b0, 1'b1);
        wr(16'h0004, 2'h3);
        mem(1, 22'h001800, 2'h1, 1'b0, 1'b1);
        rd(16'h05b4);
        wr(16'h0000, 2'h3);
        rd(16'h00c0);
        tally_and_finish;
    end
endmodule
